//--- clkcfg_pkg.sv
/*
  Constants, register layouts and shared decoders for the serial-bus clock
  configuration and monitor block.
  Assumes a single 125 MHz reference clock.
*/
package clkcfg_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned REF_HZ        = 1000000000 / CLK_PERIOD_NS;
  localparam int unsigned BASE_HZ_48    = 48000;
  localparam int unsigned BASE_HZ_44    = 44100;
  localparam int unsigned RATE_DIV      = 6;
  localparam int unsigned RATE_TOL_SHIFT = 5;
  // Two periods of the slowest frame rate without a frame edge means no bus
  localparam int unsigned MONITOR_TIMEOUT = 2 * REF_HZ / (BASE_HZ_44 / RATE_DIV);

  // ==========================================================================
  // Register map
  localparam logic [7:0] ADDR_MASTER_CFG = 8'h13;
  localparam logic [7:0] ADDR_RATE_RATIO = 8'h14;
  localparam logic [7:0] ADDR_MONITOR    = 8'h15;
  localparam logic [7:0] ADDR_ROOT_SRC   = 8'h16;
  localparam logic [7:0] ADDR_MIC_DIV    = 8'h1F;
  localparam logic [7:0] RST_MASTER_CFG  = 8'h02;
  localparam logic [7:0] RST_RATE_RATIO  = 8'h48;
  localparam logic [7:0] RST_MONITOR     = 8'hFF;
  localparam logic [7:0] RST_ROOT_SRC    = 8'h10;
  localparam logic [7:0] RST_MIC_DIV     = 8'h40;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  localparam logic [3:0] CODE_INVALID    = 4'hF;
  localparam logic [3:0] RATE_CODE_MAX   = 4'h8;
  localparam logic [3:0] RATIO_CODE_MAX  = 4'hC;

  // ==========================================================================
  // Field layouts
  typedef struct packed {
    logic       master_slave_select;
    logic       auto_config_disable;
    logic       auto_config_pll_disable;
    logic       clock_gate;
    logic       rate_family_select;
    logic [2:0] master_clock_fixed_freq;
  } master_cfg_t;

  typedef struct packed {
    logic [3:0] rate;
    logic [3:0] ratio;
  } rate_ratio_t;

  typedef struct packed {
    logic       slave_nopll_root_source;
    logic       master_clock_select_mode;
    logic [2:0] mclk_ratio_sel;
    logic       spare2;
    logic       invert_bitclk_for_framegen;
    logic       spare0;
  } root_src_t;

  typedef struct packed {
    logic [5:0] spare;
    logic [1:0] mic_clock_divider;
  } mic_cfg_t;

  // Clock plan handed to the rest of the converter
  typedef struct packed {
    logic [3:0]  eff_rate;
    logic [3:0]  eff_ratio;
    logic        root_from_mclk;
    logic        pll_enable;
    logic        mclk_use_ratio;
    logic [2:0]  mclk_fixed_sel;
    logic [11:0] mclk_ratio;
    logic        mic_pair2_ok;
  } clk_state_t;

  // ==========================================================================
  // Decoders
  function automatic logic [19:0] rate_hz(input logic [3:0] code, input logic fam44);
    int unsigned m;
    m = 0;
    unique case (code)
      4'h0: m = 1;
      4'h1: m = 2;
      4'h2: m = 3;
      4'h3: m = 4;
      4'h4: m = 6;
      4'h5: m = 12;
      4'h6: m = 24;
      4'h7: m = 48;
      4'h8: m = 96;
      default: m = 0;
    endcase
    return 20'((fam44 ? BASE_HZ_44 : BASE_HZ_48) * m / RATE_DIV);
  endfunction

  function automatic logic [11:0] ratio_val(input logic [3:0] code);
    unique case (code)
      4'h0: return 12'h010;
      4'h1: return 12'h018;
      4'h2: return 12'h020;
      4'h3: return 12'h030;
      4'h4: return 12'h040;
      4'h5: return 12'h060;
      4'h6: return 12'h080;
      4'h7: return 12'h0C0;
      4'h8: return 12'h100;
      4'h9: return 12'h180;
      4'hA: return 12'h200;
      4'hB: return 12'h400;
      4'hC: return 12'h800;
      default: return 12'h000;
    endcase
  endfunction

  function automatic logic [11:0] mclk_ratio_val(input logic [2:0] code);
    unique case (code)
      3'h0: return 12'h040;
      3'h1: return 12'h100;
      3'h2: return 12'h180;
      3'h3: return 12'h200;
      3'h4: return 12'h300;
      3'h5: return 12'h400;
      3'h6: return 12'h600;
      3'h7: return 12'h900;
    endcase
  endfunction

  // Microphone clock as a multiple of the family base rate
  function automatic logic [23:0] mic_hz(input logic [1:0] div, input logic fam44);
    logic [7:0] m;
    unique case (div)
      2'h0: m = 8'h40;
      2'h1: m = 8'h20;
      2'h2: m = 8'h10;
      2'h3: m = 8'h80;
    endcase
    return 24'((fam44 ? BASE_HZ_44 : BASE_HZ_48) * m);
  endfunction

endpackage

//--- serial_bus_host.sv
/*
  Bus host model: bit clock and frame sync toward a slave device.
  Assumes the bench holds run low while the device is bus master.
*/
`timescale 1ns/1ps
module serial_bus_host #(
  parameter int HALF = 5
) (
  // Clock and control
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [11:0] ratio,
  // Bus clocks
  output logic             bclk,
  output logic             frame_sync
);
  // ==========================================================================
  // Frame generator
  int ph;
  int bit_n;

  always_ff @(posedge clk) begin
    if (!run) begin
      ph    <= 0;
      bit_n <= 0;
      bclk  <= 1'b0;
      frame_sync <= 1'b0;
    end else if (ph == HALF - 1) begin
      ph   <= 0;
      bclk <= !bclk;
      // Frame sync moves with the rising bit clock edge
      if (!bclk) begin
        frame_sync <= (bit_n == 0);
        bit_n <= (bit_n == int'(ratio) - 1) ? 0 : bit_n + 1;
      end
    end else begin
      ph <= ph + 1;
    end
  end
endmodule

//--- serial_clock_config.sv
/*
  Serial-bus clock configuration and monitor: control registers, master-mode
  bit clock and frame sync generation, bus rate and ratio detection, root
  clock selection and digital microphone clock generation.
  Assumes a register port on REF_CLK and bus pins that are asynchronous.
*/
// Summary of operation
// R1: Rate code 0-8 selects sample rate pair
// R2: Slave auto mode ignores programmed rate, ratio
// R3: Ratio code selects bit clocks per frame
// R4: Report detected rate code, 15 invalid
// R5: Report detected ratio code, 15 invalid
// R6: Status reads all ones after reset
// R7: Slave no-PLL root: bit or master clock
// R8: Select mode picks fixed or ratio mclk in auto mode
// R9: Mclk ratio code selects 64 to 2304
// R10: Invert bit clock only for frame sync
// R11: Divider code sets microphone clock rate
// R12: Software writes reserved bits at reset values
// R13: Family bit picks 48k or 44.1k multiples
// R14: Master drives bit clock, frame sync; slave receives
// R15: PLL disabled in auto mode when bit set
// R16: Monitor continuously, invalid when nothing matches
`timescale 1ns/1ps
module serial_clock_config
  import clkcfg_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = MONITOR_TIMEOUT,
  parameter int unsigned PERIOD_W    = 20
) (
  // Clock, reset, enable
  input  wire logic       REF_CLK,
  input  wire logic       RESET,
  input  wire logic       CE,
  // Register port
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  output logic      [7:0] REG_RDATA,
  // Serial bus clocks
  input  wire logic       BCLK_I,
  output logic            BCLK_O,
  output logic            BCLK_OE,
  input  wire logic       FRAME_SYNC_I,
  output logic            FRAME_SYNC_O,
  output logic            FRAME_SYNC_OE,
  // Microphone clock and clock plan
  output logic            MIC_CLK_O,
  output clk_state_t      CLK_STATE
);

  localparam logic [32:0] REF_HZ_W  = 33'(REF_HZ);
  localparam logic [PERIOD_W-1:0] TIMEOUT_W = PERIOD_W'(TIMEOUT_CYC);
  localparam logic [11:0] BITS_MAX  = 12'hFFF;

  // ==========================================================================
  // Helpers
  // Phase step of a toggle generator: returns toggle flag and next phase
  function automatic logic [33:0] nco(input logic [32:0] acc, input logic [32:0] step);
    logic [32:0] s;
    logic [32:0] sum;
    s = (step > REF_HZ_W) ? REF_HZ_W : step;
    sum = acc + s;
    if (sum >= REF_HZ_W) begin
      return {1'b1, 33'(sum - REF_HZ_W)};
    end
    return {1'b0, sum};
  endfunction

  function automatic logic [3:0] rate_match(input logic [PERIOD_W-1:0] per);
    int unsigned nom;
    int unsigned tol;
    logic [3:0]  code;
    code = CODE_INVALID;
    for (int i = 0; i <= int'(RATE_CODE_MAX); i++) begin
      for (int f = 0; f < 2; f++) begin
        nom = REF_HZ / rate_hz(4'(i), f[0]);
        tol = nom >> RATE_TOL_SHIFT;
        if (per >= nom - tol && per <= nom + tol) begin
          code = 4'(i);
        end
      end
    end
    return code;
  endfunction

  function automatic logic [3:0] ratio_match(input logic [11:0] bits);
    logic [3:0] code;
    code = CODE_INVALID;
    for (int i = 0; i <= int'(RATIO_CODE_MAX); i++) begin
      if (bits == ratio_val(4'(i))) begin
        code = 4'(i);
      end
    end
    return code;
  endfunction

  // ==========================================================================
  // Registers
  master_cfg_t mcfg_r;
  rate_ratio_t prog_r;
  rate_ratio_t mon_r;
  root_src_t   root_r;
  mic_cfg_t    mic_r;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  wire         wr_en = CE && REG_WR;

  // Control register writes, reserved bits stored as written
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mcfg_r <= RST_MASTER_CFG;
      prog_r <= RST_RATE_RATIO;
      root_r <= RST_ROOT_SRC;
      mic_r  <= RST_MIC_DIV;
    end else if (wr_en) begin
      if (REG_ADDR == ADDR_MASTER_CFG) mcfg_r <= REG_WDATA;
      if (REG_ADDR == ADDR_RATE_RATIO) prog_r <= REG_WDATA;
      if (REG_ADDR == ADDR_ROOT_SRC)   root_r <= REG_WDATA;
      if (REG_ADDR == ADDR_MIC_DIV)    mic_r  <= REG_WDATA;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    unique case (REG_ADDR)
      ADDR_MASTER_CFG: rdata_nxt = mcfg_r;
      ADDR_RATE_RATIO: rdata_nxt = prog_r;
      ADDR_MONITOR:    rdata_nxt = mon_r;
      ADDR_ROOT_SRC:   rdata_nxt = root_r;
      ADDR_MIC_DIV:    rdata_nxt = mic_r;
      default:         rdata_nxt = READ_ZERO;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) rdata_r <= READ_ZERO;
    else if (CE) rdata_r <= rdata_nxt;
  end
  assign REG_RDATA = rdata_r;

  // ==========================================================================
  // Mode decode
  wire is_master  = mcfg_r.master_slave_select;
  wire auto_en    = !mcfg_r.auto_config_disable;
  wire slave_auto = !is_master && auto_en;
  wire fam44      = mcfg_r.rate_family_select;

  // ==========================================================================
  // Master bit clock and frame sync generation
  // R1: Programmed rate selects bit clock
  // R13: Family bit picks rate member
  // R3: Programmed ratio sets frame length
  wire [19:0] prog_hz    = rate_hz(prog_r.rate, fam44);
  wire [11:0] prog_bits  = ratio_val(prog_r.ratio);
  wire [32:0] bclk_step  = (33'(prog_hz) * 33'(prog_bits)) << 1;
  wire        gen_run    = is_master && !mcfg_r.clock_gate;
  logic [32:0] bacc_r;
  logic        bclk_r;
  logic        frame_sync_r;
  logic        oe_r;
  logic [11:0] bidx_r;
  wire  [33:0] bnco      = nco(bacc_r, bclk_step);
  wire         btog      = gen_run && bnco[33];
  // R10: Frame edge polarity follows invert bit
  wire         frame_edge = btog && (bclk_r == root_r.invert_bitclk_for_framegen);
  wire         last_bit  = (bidx_r >= prog_bits - 12'h001);
  wire  [11:0] bidx_nxt  = last_bit ? 12'h000 : 12'(bidx_r + 12'h001);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      bacc_r  <= '0;
      bclk_r  <= 1'b0;
      frame_sync_r <= 1'b0;
      bidx_r  <= '0;
      oe_r    <= 1'b0;
    end else if (CE) begin
      // R14: Drive pins only in master mode
      oe_r <= is_master;
      if (!gen_run) begin
        bacc_r  <= '0;
        bclk_r  <= 1'b0;
        frame_sync_r <= 1'b0;
        bidx_r  <= '0;
      end else begin
        bacc_r <= bnco[32:0];
        if (btog) bclk_r <= !bclk_r;
        if (frame_edge) begin
          bidx_r  <= bidx_nxt;
          frame_sync_r <= (bidx_nxt == 12'h000);
        end
      end
    end
  end
  assign BCLK_O   = bclk_r;
  assign FRAME_SYNC_O  = frame_sync_r;
  assign BCLK_OE  = oe_r;
  assign FRAME_SYNC_OE = oe_r;

  // ==========================================================================
  // Bus monitor
  logic [2:0] bsync_r;
  logic [2:0] frame_sync_s_r;
  logic [PERIOD_W-1:0] per_r;
  logic [11:0] bits_r;

  // Two-stage synchronisers plus one stage for edge detection
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      bsync_r   <= '0;
      frame_sync_s_r <= '0;
    end else if (CE) begin
      bsync_r   <= {bsync_r[1:0], BCLK_I};
      frame_sync_s_r <= {frame_sync_s_r[1:0], FRAME_SYNC_I};
    end
  end
  wire b_rise = bsync_r[1] && !bsync_r[2];
  wire f_rise = frame_sync_s_r[1] && !frame_sync_s_r[2];
  wire timed_out = (per_r >= TIMEOUT_W);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      // R6: Invalid until measured
      mon_r <= RST_MONITOR;
      per_r <= '0;
      bits_r <= '0;
    end else if (CE) begin
      if (f_rise) begin
        // R4: Detected rate code
        // R5: Detected ratio code
        // R16: Continuous update on each frame
        mon_r  <= {rate_match(per_r), ratio_match(bits_r)};
        per_r  <= PERIOD_W'(1);
        bits_r <= b_rise ? 12'h001 : 12'h000;
      end else begin
        if (!timed_out) per_r <= PERIOD_W'(per_r + PERIOD_W'(1));
        // R16: Revert to invalid on silence
        if (timed_out) mon_r <= RST_MONITOR;
        if (b_rise && bits_r != BITS_MAX) bits_r <= 12'(bits_r + 12'h001);
      end
    end
  end

  // ==========================================================================
  // Clock plan
  // R2: Slave auto uses detected values
  assign CLK_STATE.eff_rate  = slave_auto ? mon_r.rate : prog_r.rate;
  assign CLK_STATE.eff_ratio = slave_auto ? mon_r.ratio : prog_r.ratio;
  // R7: Root source in slave no-PLL mode
  assign CLK_STATE.root_from_mclk = slave_auto && mcfg_r.auto_config_pll_disable && root_r.slave_nopll_root_source;
  // R15: PLL bypass in auto mode
  assign CLK_STATE.pll_enable = !(auto_en && mcfg_r.auto_config_pll_disable);
  // R8: Master clock interpretation
  assign CLK_STATE.mclk_use_ratio = auto_en && root_r.master_clock_select_mode;
  assign CLK_STATE.mclk_fixed_sel = mcfg_r.master_clock_fixed_freq;
  // R9: Master clock to frame ratio
  assign CLK_STATE.mclk_ratio = mclk_ratio_val(root_r.mclk_ratio_sel);
  // R11: Fastest divider only for pair one
  assign CLK_STATE.mic_pair2_ok = (mic_r.mic_clock_divider != 2'h3);

  // ==========================================================================
  // Microphone clock
  // R11: Divider sets microphone clock
  logic [32:0] macc_r;
  logic        mic_r_clk;
  wire  [33:0] mnco = nco(macc_r, 33'(mic_hz(mic_r.mic_clock_divider, fam44)) << 1);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      macc_r    <= '0;
      mic_r_clk <= 1'b0;
    end else if (CE) begin
      macc_r <= mnco[32:0];
      if (mnco[33]) mic_r_clk <= !mic_r_clk;
    end
  end
  assign MIC_CLK_O = mic_r_clk;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  a_status_after_reset: assert property ($fell(RESET) |-> mon_r == RST_MONITOR) // R6
    else $error("status not invalid after reset");
  a_rate_code_legal: assert property (mon_r.rate <= RATE_CODE_MAX || mon_r.rate == CODE_INVALID) // R4
    else $error("illegal detected rate code");
  a_ratio_code_legal: assert property (mon_r.ratio <= RATIO_CODE_MAX || mon_r.ratio == CODE_INVALID) // R5
    else $error("illegal detected ratio code");
  a_oe_follows_mode: assert property (CE && $changed(is_master) |=> BCLK_OE == $past(is_master)) // R14
    else $error("pin enable does not follow master mode");
  a_slave_ignore_prog: assert property (slave_auto && $stable(mcfg_r) && $stable(mon_r) && $changed(prog_r) // R2
    |-> $stable(CLK_STATE.eff_rate) && $stable(CLK_STATE.eff_ratio))
    else $error("programmed rate leaked in slave auto mode");
  a_root_select: assert property (CLK_STATE.root_from_mclk |-> !is_master && mcfg_r.auto_config_pll_disable) // R7
    else $error("master clock root outside slave no-PLL mode");
  a_pll_bypass: assert property (auto_en && mcfg_r.auto_config_pll_disable |-> !CLK_STATE.pll_enable) // R15
    else $error("PLL enabled while disabled in auto mode");
  a_silence_invalid: assert property (CE && timed_out && !f_rise |=> mon_r == RST_MONITOR) // R16
    else $error("status not invalid after bus silence");
  a_frame_one_pulse: assert property (CE && frame_edge && !last_bit && gen_run |=> !FRAME_SYNC_O) // R3
    else $error("frame sync outside frame start");
  a_no_drive_slave: assert property (CE && !is_master |=> !BCLK_O && !FRAME_SYNC_O && !BCLK_OE) // R14
    else $error("bit clock generated in slave mode");

  c_master_frame: cover property (gen_run && $rose(FRAME_SYNC_O));
  c_detect_valid: cover property (f_rise ##1 mon_r.rate != CODE_INVALID);
  c_slave_root_mclk: cover property (CLK_STATE.root_from_mclk);

endmodule

//--- test_audio_serial_clock_config.sv
/*
  Self-checking bench for serial_clock_config with a bus host model.
  Assumes clkcfg_pkg and serial_bus_host are compiled first.
*/
`timescale 1ns/1ps
module test_audio_serial_clock_config
  import clkcfg_pkg::*;
;
  // ==========================================================================
  // Signals
  logic        ref_clk;
  logic        rst;
  logic        reg_wr;
  logic        ce;
  logic        run;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        bclk_o, bclk_oe, frame_sync_o, frame_sync_oe, mic_o, hb, hf;
  logic [11:0] ratio;
  logic [31:0] seed;
  logic [7:0]  d;
  logic [11:0] snap;
  clk_state_t  st;
  int          miscompares, num_checks;
  int          nl[6] = '{16, 32, 24, 20, 16, 32};
  int          mr[8] = '{64, 256, 384, 512, 768, 1024, 1536, 2304};
  int          mm[4] = '{64, 32, 16, 128};
  wire logic   bclk_w  = bclk_oe ? bclk_o : hb;
  wire logic   frame_sync_w = frame_sync_oe ? frame_sync_o : hf;

  // ==========================================================================
  // Instances
  serial_clock_config #(.TIMEOUT_CYC(400), .PERIOD_W(20)) dut (
    .REF_CLK(ref_clk), .RESET(rst), .CE(ce), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(reg_wr), .REG_RDATA(rdata), .BCLK_I(bclk_w), .BCLK_O(bclk_o), .BCLK_OE(bclk_oe),
    .FRAME_SYNC_I(frame_sync_w), .FRAME_SYNC_O(frame_sync_o), .FRAME_SYNC_OE(frame_sync_oe), .MIC_CLK_O(mic_o), .CLK_STATE(st));
  serial_bus_host host (.clk(ref_clk), .run(run), .ratio(ratio), .bclk(hb), .frame_sync(hf));

  // Reference clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================================
  // Helpers
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %0t %s", $time, m);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    addr   = a;
    wdata  = v;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    // Idle edge so a following write raises the strobe afresh
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    step(1);
    chk(rdata, exp, "read data");
  endtask

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // Rate code whose nominal frame period lies within 1/32
  function automatic logic [3:0] rate_code(input int cyc);
    int  m[9] = '{1, 2, 3, 4, 6, 12, 24, 48, 96};
    real p;
    rate_code = 4'hF;
    for (int i = 0; i < 9; i++) begin
      for (int f = 0; f < 2; f++) begin
        p = 750.0e6 / ((f ? 44100.0 : 48000.0) * m[i]);
        if (cyc - p <= p / 32 && p - cyc <= p / 32) rate_code = 4'(i);
      end
    end
  endfunction

  function automatic logic [3:0] ratio_code(input int n);
    int r[13] = '{16, 24, 32, 48, 64, 96, 128, 192, 256, 384, 512, 1024, 2048};
    ratio_code = 4'hF;
    for (int i = 0; i < 13; i++) if (r[i] == n) ratio_code = 4'(i);
  endfunction

  // Master frame: bits per frame, period window, edge polarity
  task automatic mst(input logic [7:0] cfg, input logic inv, input int lo, input int hi);
    int   n, cyc, edges;
    logic pf, pb;
    n = 0;
    cyc = 0;
    edges = 0;
    wr(8'h16, {6'h04, inv, 1'b0});
    wr(8'h13, cfg);
    step(1);
    chk({bclk_oe, frame_sync_oe}, 12'h003, "drive enable");
    for (int i = 0; i < 3000 && n < 2; i++) begin
      pf = frame_sync_o;
      pb = bclk_o;
      step(1);
      if (n == 1) cyc++;
      if (n == 1 && bclk_o && !pb) edges++;
      if (frame_sync_o && !pf) n++;
      if (frame_sync_o && !pf && n == 1) chk(bclk_o, !inv, "frame edge");
    end
    chk(edges, 16, "bits per frame");
    chk(cyc >= lo && cyc <= hi, 1, "frame period");
  endtask

  task test_done;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    run = 1'b0;
    ratio = 12'h010;
    miscompares = 0;
    num_checks = 0;
    seed = 32'h4068;
    step(16);
    rst = 1'b0;
    // Reset values, read-only and unmapped places
    rd(8'h15, 8'hFF);
    rd(8'h14, 8'h48);
    rd(8'h16, 8'h10);
    rd(8'h1F, 8'h40);
    rd(8'h30, 8'h00);
    wr(8'h15, 8'h00);
    rd(8'h15, 8'hFF);
    // Clock enable low freezes read data and blocks writes
    ce = 1'b0;
    wr(8'h14, 8'h33);
    chk(rdata, 8'hFF, "frozen read");
    ce = 1'b1;
    rd(8'h14, 8'h48);
    // Random rate, ratio and root settings
    repeat (6) begin
      seed = xs(seed);
      d = {4'(seed[3:0] % 9), 4'(seed[7:4] % 13)};
      wr(8'h14, d);
      rd(8'h14, d);
      d = seed[15:8] & 8'hFA;
      wr(8'h16, d);
      rd(8'h16, d);
      chk(st.mclk_ratio, 12'(mr[d[5:3]]), "mclk ratio");
    end
    // Clock plan flags
    wr(8'h13, 8'h20);
    chk(st.pll_enable, 0, "pll");
    wr(8'h16, 8'h90);
    chk(st.root_from_mclk, 1, "root mclk");
    wr(8'h16, 8'h50);
    chk({st.root_from_mclk, st.mclk_use_ratio}, 1, "root bclk");
    wr(8'h13, 8'h62);
    chk({st.pll_enable, st.mclk_use_ratio, st.mclk_fixed_sel}, 12'h012, "manual");
    wr(8'h13, 8'h00);
    snap = {st.eff_rate, st.eff_ratio};
    wr(8'h14, 8'h21);
    chk({st.eff_rate, st.eff_ratio}, snap, "slave ignores");
    // Monitor against the host at several ratios
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      ratio = 12'(k < 6 ? nl[k] : nl[seed % 6]);
      run = 1'b1;
      step(40 * int'(ratio));
      rd(8'h15, {rate_code(10 * int'(ratio)), ratio_code(int'(ratio))});
      run = 1'b0;
      // Let the host see its stop before the next frame setting
      step(1);
    end
    step(450);
    rd(8'h15, 8'hFF);
    // Master generation, both families and inverted polarity
    // Manual clocking so the plan shows the programmed values
    wr(8'h13, 8'h40);
    wr(8'h14, 8'h80);
    chk({st.eff_rate, st.eff_ratio}, 12'h080, "master plan");
    mst(8'h80, 1'b0, 158, 168);
    mst(8'h88, 1'b0, 172, 182);
    mst(8'h80, 1'b1, 158, 168);
    wr(8'h13, 8'h00);
    step(1);
    chk({bclk_oe, frame_sync_oe}, 12'h000, "slave release");
    // Microphone clock divider codes
    for (int c = 0; c < 4; c++) begin
      int  r, cyc;
      real e;
      logic pm;
      r = 0;
      cyc = 0;
      e = 8.0 * 125.0e6 / (48000.0 * mm[c]);
      wr(8'h1F, 8'h40 | 8'(c));
      chk(st.mic_pair2_ok, c != 3, "pair flag");
      for (int i = 0; i < 3000 && r < 10; i++) begin
        pm = mic_o;
        step(1);
        if (r >= 2) cyc++;
        if (mic_o && !pm) r++;
      end
      chk(cyc > e - 3.0 && cyc < e + 3.0, 1, "mic period");
    end
    test_done;
  end
endmodule
